/* pbr_pkg.sv */
package pbr_pkg;

	// clock and timing
	localparam int unsigned CLK_FREQ_HZ      = 20_000_000;
	localparam int unsigned CYC_PER_US       = CLK_FREQ_HZ / 1_000_000;
	localparam int unsigned CYC_PER_MS       = CLK_FREQ_HZ / 1_000;
	localparam int unsigned NOTIFY_PULSE_US  = 128;
	localparam int unsigned NOTIFY_PULSE_CYC = NOTIFY_PULSE_US * CYC_PER_US;
	localparam int unsigned NOTIFY_W         = 12;
	localparam int unsigned HOLD_W           = 29;
	localparam int unsigned WAKE_SHORT_MS    = 80;
	localparam int unsigned WAKE_LONG_MS     = 1_000;
	localparam int unsigned RESET_HOLD0_MS   = 5_000;
	localparam int unsigned RESET_HOLD1_MS   = 9_000;
	localparam int unsigned RESET_HOLD2_MS   = 11_000;
	localparam int unsigned RESET_HOLD3_MS   = 15_000;
	localparam int unsigned RESET_PULSE_MS   = 400;

	// register byte offsets
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_BUTTON = 8'h04;
	localparam logic [7:0] REG_STATUS = 8'h08;

	// control register fields
	localparam int unsigned CTRL_WAKE_SEL    = 0;
	localparam int unsigned CTRL_RESET_SEL   = 1;
	localparam int unsigned CTRL_RECOVERY    = 3;
	localparam int unsigned CTRL_NEEDS_INPUT = 4;
	localparam int unsigned CTRL_CHARGE_EN   = 5;
	localparam int unsigned CTRL_SYS_EN      = 6;
	localparam int unsigned CTRL_MODE        = 8;

	// button register fields
	localparam int unsigned BTN_WAKE_FIRST  = 0;
	localparam int unsigned BTN_WAKE_SECOND = 1;
	localparam int unsigned BTN_RESET_FAULT = 2;

	// status register fields
	localparam int unsigned STAT_STATE    = 0;
	localparam int unsigned STAT_OV       = 2;
	localparam int unsigned STAT_UV       = 3;
	localparam int unsigned STAT_ILIM     = 4;
	localparam int unsigned STAT_DPM      = 5;
	localparam int unsigned STAT_TIMER    = 6;
	localparam int unsigned STAT_TEMP     = 7;
	localparam int unsigned STAT_PG       = 10;
	localparam int unsigned STAT_RST_BUSY = 11;

	// reset values and bus response codes
	localparam logic       RST_CHARGE_EN = 1'b1;
	localparam logic       RST_SYS_EN    = 1'b1;
	localparam logic [1:0] RESP_OKAY     = 2'h0;
	localparam logic [1:0] RESP_SLVERR   = 2'h2;

	typedef enum logic [2:0] {
		MODE_READY      = 3'b000,
		MODE_CHARGE     = 3'b001,
		MODE_ACTIVE_BAT = 3'b010,
		MODE_SHIP       = 3'b011,
		MODE_HIZ        = 3'b100
	} pbr_mode_e;

	typedef enum logic [1:0] {
		CHG_READY    = 2'b00,
		CHG_CHARGING = 2'b01,
		CHG_DONE     = 2'b10,
		CHG_FAULT    = 2'b11
	} pbr_chg_state_e;

	typedef enum logic [2:0] {
		TEMP_NORMAL = 3'b000,
		TEMP_COLD   = 3'b001,
		TEMP_COOL   = 3'b010,
		TEMP_WARM   = 3'b011,
		TEMP_HOT    = 3'b100
	} pbr_temp_e;

	typedef struct packed {
		logic [7:0]  awaddr;
		logic        awvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        wvalid;
		logic        bready;
		logic [7:0]  araddr;
		logic        arvalid;
		logic        rready;
	} pbr_axi_req_s;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic [1:0]  bresp;
		logic        bvalid;
		logic        arready;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		logic        rvalid;
	} pbr_axi_rsp_s;

	typedef struct packed {
		logic      battery_present;
		logic      input_valid;
		logic      input_stable;
		logic      input_in_window;
		logic      input_overvoltage;
		logic      input_undervoltage;
		logic      input_current_limit;
		logic      input_power_mgmt;
		logic      safety_timer_fault;
		pbr_temp_e temp_zone;
		logic      charge_done;
	} pbr_cond_s;

	typedef struct packed {
		logic charge_en;
		logic temp_sense_en;
		logic power_good_out;
		logic halve_charge_current;
		logic lower_regulation_target;
		logic reduce_input_current;
		logic limit_input_current;
		logic recharge_watch;
	} pbr_chg_s;

endpackage : pbr_pkg

/* pbr_supervisor.sv */
// The implementer's own choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none

module pbr_supervisor #(
	parameter logic [pbr_pkg::HOLD_W-1:0] WAKE_SHORT_CYC  = pbr_pkg::HOLD_W'(pbr_pkg::WAKE_SHORT_MS * pbr_pkg::CYC_PER_MS),
	parameter logic [pbr_pkg::HOLD_W-1:0] WAKE_LONG_CYC   = pbr_pkg::HOLD_W'(pbr_pkg::WAKE_LONG_MS * pbr_pkg::CYC_PER_MS),
	parameter logic [pbr_pkg::HOLD_W-1:0] RESET_HOLD0_CYC = pbr_pkg::HOLD_W'(pbr_pkg::RESET_HOLD0_MS * pbr_pkg::CYC_PER_MS),
	parameter logic [pbr_pkg::HOLD_W-1:0] RESET_HOLD1_CYC = pbr_pkg::HOLD_W'(pbr_pkg::RESET_HOLD1_MS * pbr_pkg::CYC_PER_MS),
	parameter logic [pbr_pkg::HOLD_W-1:0] RESET_HOLD2_CYC = pbr_pkg::HOLD_W'(pbr_pkg::RESET_HOLD2_MS * pbr_pkg::CYC_PER_MS),
	parameter logic [pbr_pkg::HOLD_W-1:0] RESET_HOLD3_CYC = pbr_pkg::HOLD_W'(pbr_pkg::RESET_HOLD3_MS * pbr_pkg::CYC_PER_MS),
	parameter logic [pbr_pkg::HOLD_W-1:0] RESET_PULSE_CYC = pbr_pkg::HOLD_W'(pbr_pkg::RESET_PULSE_MS * pbr_pkg::CYC_PER_MS)
) (
	// clock and reset
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	// register bus
	input  wire pbr_pkg::pbr_axi_req_s axi_req,
	output var  pbr_pkg::pbr_axi_rsp_s axi_rsp,
	// button and supply conditions, asynchronous
	input  wire logic                  button_in_n,
	input  wire pbr_pkg::pbr_cond_s    cond_in,
	// host side
	output var  logic                  host_notify,
	output var  logic                  reset_out_n,
	// power path and charger control
	output var  pbr_pkg::pbr_mode_e    op_mode,
	output var  logic                  system_output_en,
	output var  pbr_pkg::pbr_chg_s     charger
);

	localparam logic [pbr_pkg::NOTIFY_W-1:0] NOTIFY_CYC = pbr_pkg::NOTIFY_W'(pbr_pkg::NOTIFY_PULSE_CYC);
	localparam logic [pbr_pkg::HOLD_W-1:0]   HOLD_MAX   = '1;

	// synchronisers
	logic                        btn_meta;
	logic                        btn_sync;
	pbr_pkg::pbr_cond_s          cond_meta;
	pbr_pkg::pbr_cond_s          cond;
	pbr_pkg::pbr_cond_s          cond_q;

	// control fields
	logic                        button_wake_select;
	logic [1:0]                  button_reset_select;
	logic                        button_recovery_select;
	logic                        reset_needs_input_select;
	logic                        charge_enable;

	// button tracking
	logic [pbr_pkg::HOLD_W-1:0]  hold_cnt;
	logic [pbr_pkg::HOLD_W-1:0]  wake_time;
	logic [pbr_pkg::HOLD_W-1:0]  reset_time;
	logic [pbr_pkg::HOLD_W-1:0]  rst_cnt;
	logic                        reset_armed;
	pbr_pkg::pbr_mode_e          prior_mode;
	logic                        prior_sys_en;
	logic                        button_active;
	logic                        btn_low;
	logic                        wake_hit;
	logic                        reset_hit;
	logic                        reset_end;
	logic                        wake_flag_first;
	logic                        wake_flag_second;
	logic                        reset_fault;

	// fault tracking
	logic                        fault_event;
	logic [pbr_pkg::NOTIFY_W-1:0] notify_cnt;
	pbr_pkg::pbr_chg_state_e     charge_state;
	pbr_pkg::pbr_chg_state_e     next_charge_state;
	pbr_pkg::pbr_chg_s           next_charger;

	// bus
	logic                        wr_fire;
	logic                        rd_fire;
	logic                        btn_read;
	logic [31:0]                 rd_word;
	logic                        rd_hit;

	// two flip-flops on button_in_n and every cond_in pin before use
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			btn_meta  <= 1'b1;
			btn_sync  <= 1'b1;
			cond_meta <= '0;
			cond      <= '0;
			cond_q    <= '0;
		end
		else
		begin
			btn_meta  <= button_in_n;
			btn_sync  <= btn_meta;
			cond_meta <= cond_in;
			cond      <= cond_meta;
			cond_q    <= cond;
		end
	end

	assign btn_low       = !btn_sync;
	assign button_active = cond.battery_present
		|| (cond.input_valid && cond.input_stable && charge_enable);

	// separate selectors for the wake hold and the reset hold
	always_comb
	begin
		wake_time = button_wake_select ? WAKE_LONG_CYC : WAKE_SHORT_CYC;
		unique case (button_reset_select)
			2'b00: reset_time = RESET_HOLD0_CYC;
			2'b01: reset_time = RESET_HOLD1_CYC;
			2'b10: reset_time = RESET_HOLD2_CYC;
			2'b11: reset_time = RESET_HOLD3_CYC;
		endcase
	end

	// hold counter restarts on every release, so a fresh press must pass the wake time again
	always_ff @(posedge aclk)
	begin
		if (!aresetn || !btn_low || !button_active)
			hold_cnt <= '0;
		else if (hold_cnt != HOLD_MAX)
			hold_cnt <= hold_cnt + 1'b1;
	end

	assign wake_hit  = btn_low && button_active && (hold_cnt == wake_time - 1'b1);
	assign reset_hit = btn_low && button_active && reset_armed
		&& (hold_cnt == reset_time - 1'b1)
		&& (hold_cnt >= wake_time - 1'b1)
		&& (!reset_needs_input_select || cond.input_in_window);
	assign reset_end = (rst_cnt == {{(pbr_pkg::HOLD_W-1){1'b0}}, 1'b1});

	// a reset fires once per press; release rearms it
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			reset_armed <= 1'b1;
		else if (reset_hit)
			reset_armed <= 1'b0;
		else if (!btn_low)
			reset_armed <= 1'b1;
	end

	// reset pulse width counter
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rst_cnt     <= '0;
			reset_out_n <= 1'b1;
		end
		else if (reset_hit)
		begin
			rst_cnt     <= RESET_PULSE_CYC;
			reset_out_n <= 1'b0;
		end
		else if (rst_cnt != '0)
		begin
			rst_cnt     <= rst_cnt - 1'b1;
			reset_out_n <= reset_end;
		end
	end

	// mode and system output remembered at the start of the press
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			prior_mode   <= pbr_pkg::MODE_READY;
			prior_sys_en <= pbr_pkg::RST_SYS_EN;
		end
		else if (btn_low && button_active && hold_cnt == '0)
		begin
			prior_mode   <= op_mode;
			prior_sys_en <= system_output_en;
		end
	end

	// operating mode and system output: software writes, reset recovery overrides
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			op_mode          <= pbr_pkg::MODE_READY;
			system_output_en <= pbr_pkg::RST_SYS_EN;
		end
		else if (reset_end)
		begin
			if (cond.input_valid)
				op_mode <= prior_mode;
			else if (button_recovery_select)
				op_mode <= pbr_pkg::MODE_HIZ;
			else
				op_mode <= pbr_pkg::MODE_SHIP;
			if (!prior_sys_en && (!cond.input_valid ? button_recovery_select
				: (prior_mode == pbr_pkg::MODE_HIZ || prior_mode == pbr_pkg::MODE_ACTIVE_BAT)))
				system_output_en <= 1'b1;
		end
		else if (wr_fire && axi_req.awaddr == pbr_pkg::REG_CTRL)
		begin
			if (axi_req.wstrb[0])
				system_output_en <= axi_req.wdata[pbr_pkg::CTRL_SYS_EN];
			if (axi_req.wstrb[1])
				op_mode <= pbr_pkg::pbr_mode_e'(axi_req.wdata[pbr_pkg::CTRL_MODE +: 3]);
		end
	end

	// sticky button flags; a new event in the reading cycle wins over the clear
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			wake_flag_first  <= 1'b0;
			wake_flag_second <= 1'b0;
			reset_fault      <= 1'b0;
		end
		else
		begin
			if (wake_hit && !button_wake_select)
				wake_flag_first <= 1'b1;
			else if (btn_read)
				wake_flag_first <= 1'b0;
			if (wake_hit && button_wake_select)
				wake_flag_second <= 1'b1;
			else if (btn_read)
				wake_flag_second <= 1'b0;
			if (reset_hit)
				reset_fault <= 1'b1;
			else if (btn_read)
				reset_fault <= 1'b0;
		end
	end

	// rising edge of any fault or status condition
	assign fault_event = (cond.input_overvoltage && !cond_q.input_overvoltage)
		|| (cond.input_undervoltage && !cond_q.input_undervoltage)
		|| (cond.input_current_limit && !cond_q.input_current_limit)
		|| (cond.input_power_mgmt && !cond_q.input_power_mgmt)
		|| (cond.safety_timer_fault && !cond_q.safety_timer_fault)
		|| (cond.temp_zone != pbr_pkg::TEMP_NORMAL && cond.temp_zone != cond_q.temp_zone)
		|| (cond.charge_done && !cond_q.charge_done);

	// notify pulse, restarted by each new event
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			notify_cnt  <= '0;
			host_notify <= 1'b0;
		end
		else if (wake_hit || reset_hit || fault_event)
		begin
			notify_cnt  <= NOTIFY_CYC;
			host_notify <= 1'b1;
		end
		else if (notify_cnt != '0)
		begin
			notify_cnt  <= notify_cnt - 1'b1;
			host_notify <= (notify_cnt != {{(pbr_pkg::NOTIFY_W-1){1'b0}}, 1'b1});
		end
	end

	// present-condition charge state and charger actions
	always_comb
	begin
		if (cond.input_overvoltage || cond.input_power_mgmt || cond.safety_timer_fault
			|| cond.temp_zone != pbr_pkg::TEMP_NORMAL)
			next_charge_state = pbr_pkg::CHG_FAULT;
		else if (cond.charge_done)
			next_charge_state = pbr_pkg::CHG_DONE;
		else if (charge_enable && cond.input_valid && !cond.input_undervoltage)
			next_charge_state = pbr_pkg::CHG_CHARGING;
		else
			next_charge_state = pbr_pkg::CHG_READY;
		next_charger.charge_en = charge_enable && !cond.input_overvoltage && !cond.input_undervoltage
			&& !cond.safety_timer_fault && !cond.charge_done
			&& cond.temp_zone != pbr_pkg::TEMP_COLD && cond.temp_zone != pbr_pkg::TEMP_HOT;
		next_charger.temp_sense_en           = !cond.safety_timer_fault && !cond.input_overvoltage
			&& !cond.input_undervoltage;
		next_charger.power_good_out          = cond.input_valid && !cond.input_overvoltage
			&& !cond.input_undervoltage;
		next_charger.halve_charge_current    = cond.temp_zone == pbr_pkg::TEMP_COOL;
		next_charger.lower_regulation_target = cond.temp_zone == pbr_pkg::TEMP_WARM;
		next_charger.reduce_input_current    = cond.input_power_mgmt;
		next_charger.limit_input_current     = cond.input_current_limit;
		next_charger.recharge_watch          = cond.charge_done;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			charge_state <= pbr_pkg::CHG_READY;
			charger      <= '0;
		end
		else
		begin
			charge_state <= next_charge_state;
			charger      <= next_charger;
		end
	end

	// bus slave: address and data taken together, one cycle after both are offered
	assign wr_fire  = axi_rsp.awready && axi_req.awvalid && axi_rsp.wready && axi_req.wvalid;
	assign rd_fire  = axi_rsp.arready && axi_req.arvalid;
	assign btn_read = rd_fire && axi_req.araddr == pbr_pkg::REG_BUTTON;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			button_wake_select       <= 1'b0;
			button_reset_select      <= 2'h0;
			button_recovery_select   <= 1'b0;
			reset_needs_input_select <= 1'b0;
			charge_enable            <= pbr_pkg::RST_CHARGE_EN;
		end
		else if (wr_fire && axi_req.awaddr == pbr_pkg::REG_CTRL && axi_req.wstrb[0])
		begin
			button_wake_select       <= axi_req.wdata[pbr_pkg::CTRL_WAKE_SEL];
			button_reset_select      <= axi_req.wdata[pbr_pkg::CTRL_RESET_SEL +: 2];
			button_recovery_select   <= axi_req.wdata[pbr_pkg::CTRL_RECOVERY];
			reset_needs_input_select <= axi_req.wdata[pbr_pkg::CTRL_NEEDS_INPUT];
			charge_enable            <= axi_req.wdata[pbr_pkg::CTRL_CHARGE_EN];
		end
	end

	always_comb
	begin
		rd_word = '0;
		rd_hit  = 1'b1;
		unique case (axi_req.araddr)
			pbr_pkg::REG_CTRL:
			begin
				rd_word[pbr_pkg::CTRL_WAKE_SEL]       = button_wake_select;
				rd_word[pbr_pkg::CTRL_RESET_SEL +: 2] = button_reset_select;
				rd_word[pbr_pkg::CTRL_RECOVERY]       = button_recovery_select;
				rd_word[pbr_pkg::CTRL_NEEDS_INPUT]    = reset_needs_input_select;
				rd_word[pbr_pkg::CTRL_CHARGE_EN]      = charge_enable;
				rd_word[pbr_pkg::CTRL_SYS_EN]         = system_output_en;
				rd_word[pbr_pkg::CTRL_MODE +: 3]      = op_mode;
			end
			pbr_pkg::REG_BUTTON:
			begin
				rd_word[pbr_pkg::BTN_WAKE_FIRST]  = wake_flag_first;
				rd_word[pbr_pkg::BTN_WAKE_SECOND] = wake_flag_second;
				rd_word[pbr_pkg::BTN_RESET_FAULT] = reset_fault;
			end
			pbr_pkg::REG_STATUS:
			begin
				rd_word[pbr_pkg::STAT_STATE +: 2] = charge_state;
				rd_word[pbr_pkg::STAT_OV]         = cond.input_overvoltage;
				rd_word[pbr_pkg::STAT_UV]         = cond.input_undervoltage;
				rd_word[pbr_pkg::STAT_ILIM]       = cond.input_current_limit;
				rd_word[pbr_pkg::STAT_DPM]        = cond.input_power_mgmt;
				rd_word[pbr_pkg::STAT_TIMER]      = cond.safety_timer_fault;
				rd_word[pbr_pkg::STAT_TEMP +: 3]  = cond.temp_zone;
				rd_word[pbr_pkg::STAT_PG]         = charger.power_good_out;
				rd_word[pbr_pkg::STAT_RST_BUSY]   = !reset_out_n;
			end
			default:
				rd_hit = 1'b0;
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			axi_rsp <= '0;
		else
		begin
			axi_rsp.awready <= axi_req.awvalid && axi_req.wvalid && !axi_rsp.awready && !axi_rsp.bvalid;
			axi_rsp.wready  <= axi_req.awvalid && axi_req.wvalid && !axi_rsp.awready && !axi_rsp.bvalid;
			if (wr_fire)
			begin
				axi_rsp.bvalid <= 1'b1;
				axi_rsp.bresp  <= (axi_req.awaddr == pbr_pkg::REG_CTRL) ? pbr_pkg::RESP_OKAY : pbr_pkg::RESP_SLVERR;
			end
			else if (axi_req.bready)
				axi_rsp.bvalid <= 1'b0;
			axi_rsp.arready <= axi_req.arvalid && !axi_rsp.arready && !axi_rsp.rvalid;
			if (rd_fire)
			begin
				axi_rsp.rvalid <= 1'b1;
				axi_rsp.rdata  <= rd_word;
				axi_rsp.rresp  <= rd_hit ? pbr_pkg::RESP_OKAY : pbr_pkg::RESP_SLVERR;
			end
			else if (axi_req.rready)
				axi_rsp.rvalid <= 1'b0;
		end
	end

endmodule : pbr_supervisor

`default_nettype wire

/* pbr_supervisor_assertions.sv */
`timescale 1ns/100ps
`default_nettype none
module pbr_supervisor_checker #(
	parameter logic [pbr_pkg::HOLD_W-1:0] RESET_PULSE_CYC = 30
) (
	// clock and reset
	input wire logic                  aclk,
	input wire logic                  aresetn,
	// register bus
	input wire pbr_pkg::pbr_axi_req_s axi_req,
	input wire pbr_pkg::pbr_axi_rsp_s axi_rsp,
	// button and conditions
	input wire logic                  button_in_n,
	input wire pbr_pkg::pbr_cond_s    cond_in,
	// watched outputs
	input wire logic                  host_notify,
	input wire logic                  reset_out_n,
	input wire pbr_pkg::pbr_mode_e    op_mode,
	input wire logic                  system_output_en,
	input wire pbr_pkg::pbr_chg_s     charger
);
	logic [11:0]                ncnt;
	logic [pbr_pkg::HOLD_W-1:0] rcnt;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// length of the present notify and reset pulses
	always_ff @(posedge aclk)
		if (!aresetn || !host_notify)
			ncnt <= '0;
		else if (ncnt != 12'hFFF)
			ncnt <= ncnt + 12'h001;
	always_ff @(posedge aclk)
		if (!aresetn || reset_out_n)
			rcnt <= '0;
		else
			rcnt <= rcnt + 1'b1;
	notify_width_a: assert property ($fell(host_notify) |-> ncnt >= 12'(pbr_pkg::NOTIFY_PULSE_CYC))
		else $error("notify pulse too short");
	reset_width_a: assert property ($rose(reset_out_n) |-> rcnt == RESET_PULSE_CYC)
		else $error("reset pulse width wrong");
	reset_notify_a: assert property ($fell(reset_out_n) |-> host_notify)
		else $error("reset without notify");
	reset_active_a: assert property ($fell(reset_out_n) |-> $past(cond_in.battery_present, 3) || $past(cond_in.input_valid, 3))
		else $error("reset while button inactive");
	ov_off_a: assert property (cond_in.input_overvoltage [*3] |=> !charger.charge_en && !charger.power_good_out)
		else $error("overvoltage left charging on");
	uv_off_a: assert property (cond_in.input_undervoltage [*3] |=> !charger.charge_en && !charger.power_good_out)
		else $error("undervoltage left charging on");
	dpm_reduce_a: assert property (cond_in.input_power_mgmt [*3] |=> charger.reduce_input_current)
		else $error("input current not reduced");
	timer_off_a: assert property (cond_in.safety_timer_fault [*3] |=> !charger.charge_en && !charger.temp_sense_en)
		else $error("timer fault left charging on");
	cool_half_a: assert property (cond_in.temp_zone == pbr_pkg::TEMP_COOL [*3] |=> charger.halve_charge_current)
		else $error("cool zone current not halved");
	warm_lower_a: assert property (cond_in.temp_zone == pbr_pkg::TEMP_WARM [*3] |=> charger.lower_regulation_target)
		else $error("warm zone target not lowered");
	done_watch_a: assert property (cond_in.charge_done [*3] |=> charger.recharge_watch && !charger.charge_en)
		else $error("charge done not handled");
	cover property ($fell(reset_out_n));
	cover property ($rose(host_notify) && reset_out_n);
	cover property (axi_rsp.rvalid && axi_rsp.rresp == pbr_pkg::RESP_SLVERR);
endmodule : pbr_supervisor_checker
bind pbr_supervisor pbr_supervisor_checker #(.RESET_PULSE_CYC(RESET_PULSE_CYC)) i_pbr_supervisor_checker (
	.aclk(aclk), .aresetn(aresetn), .axi_req(axi_req), .axi_rsp(axi_rsp), .button_in_n(button_in_n),
	.cond_in(cond_in), .host_notify(host_notify), .reset_out_n(reset_out_n), .op_mode(op_mode),
	.system_output_en(system_output_en), .charger(charger));
`default_nettype wire

/* pbr_button_model.sv */
`timescale 1ns/100ps
`default_nettype none
module pbr_button_model (
	// clock
	input  wire logic aclk,
	// commands from the bench
	input  wire logic press,
	input  wire logic ramping,
	// contact, pulled up while open
	output var  logic button_in_n
);
	initial button_in_n = 1'b1;
	// a press during the input ramp is held back to protect the system rail
	always @(posedge aclk)
		button_in_n <= !(press && !ramping);
endmodule : pbr_button_model
`default_nettype wire

/* pbr_supervisor_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module pbr_supervisor_tb;
	localparam logic [pbr_pkg::HOLD_W-1:0] RP = 29'd30;
	logic                  aclk = 1'b0;
	logic                  aresetn = 1'b0;
	logic                  press = 1'b0;
	logic                  button_in_n;
	logic                  host_notify;
	logic                  reset_out_n;
	logic                  system_output_en;
	pbr_pkg::pbr_axi_req_s req = '0;
	pbr_pkg::pbr_axi_rsp_s rsp;
	pbr_pkg::pbr_cond_s    cond;
	pbr_pkg::pbr_cond_s    base;
	pbr_pkg::pbr_cond_s    battery_supply;
	pbr_pkg::pbr_cond_s    nowin;
	pbr_pkg::pbr_cond_s    input_supply;
	pbr_pkg::pbr_cond_s    c;
	pbr_pkg::pbr_mode_e    op_mode;
	pbr_pkg::pbr_chg_s     charger;
	int                    n_errors = 0;
	int                    comparisons = 0;
	int                    n_falls = 0;
	int                    low_cnt = 0;
	int                    last_low = 0;
	logic [31:0]           d;
	logic [1:0]            r;
	logic [1:0]            exp_st [10] = '{2'h3, 2'h0, 2'h1, 2'h3, 2'h3, 2'h3, 2'h3, 2'h3, 2'h3, 2'h2};
	logic [7:0]            exp_chg [10] = '{8'h00, 8'h00, 8'hE2, 8'hE4, 8'h20, 8'h60, 8'hF0, 8'hE8, 8'h60, 8'h61};
	pbr_supervisor #(
		.WAKE_SHORT_CYC(29'd20), .WAKE_LONG_CYC(29'd40), .RESET_HOLD0_CYC(29'd100), .RESET_HOLD1_CYC(29'd120),
		.RESET_PULSE_CYC(RP) // the two longest reset holds keep their defaults and are not reached
	) i_pbr_supervisor (.aclk(aclk), .aresetn(aresetn), .axi_req(req), .axi_rsp(rsp), .button_in_n(button_in_n),
		.cond_in(cond), .host_notify(host_notify), .reset_out_n(reset_out_n), .op_mode(op_mode),
		.system_output_en(system_output_en), .charger(charger));
	pbr_button_model i_pbr_button_model (.aclk(aclk), .press(press),
		.ramping(cond.input_valid && !cond.input_stable), .button_in_n(button_in_n));
	initial
		forever #25 aclk = ~aclk;
	// count reset pulses and keep the width of the last one
	always @(posedge aclk)
		if (reset_out_n === 1'b0)
		begin
			if (low_cnt == 0)
				n_falls <= n_falls + 1;
			low_cnt <= low_cnt + 1;
		end
		else if (low_cnt != 0)
		begin
			last_low <= low_cnt;
			low_cnt <= 0;
		end
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic cyc(input int n);
		repeat (n) @(posedge aclk);
	endtask : cyc
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		logic aw_ok;
		logic w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		@(posedge aclk);
		req.awaddr <= a;
		req.wdata <= v;
		req.wstrb <= 4'hF;
		req.awvalid <= 1'b1;
		req.wvalid <= 1'b1;
		req.bready <= 1'b1;
		while (!(aw_ok && w_ok))
		begin
			@(posedge aclk);
			aw_ok = aw_ok || rsp.awready === 1'b1;
			w_ok = w_ok || rsp.wready === 1'b1;
			req.awvalid <= !aw_ok;
			req.wvalid <= !w_ok;
		end
		do @(posedge aclk); while (rsp.bvalid !== 1'b1);
		r = rsp.bresp;
		req.bready <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		@(posedge aclk);
		req.araddr <= a;
		req.arvalid <= 1'b1;
		req.rready <= 1'b1;
		do @(posedge aclk); while (rsp.arready !== 1'b1);
		req.arvalid <= 1'b0;
		do @(posedge aclk); while (rsp.rvalid !== 1'b1);
		d = rsp.rdata;
		r = rsp.rresp;
		req.rready <= 1'b0;
	endtask : rd
	task automatic push(input int n);
		repeat (3000) if (host_notify === 1'b1) @(posedge aclk);
		@(posedge aclk);
		press <= 1'b1;
		cyc(n);
		press <= 1'b0;
		cyc(40);
	endtask : push
	task automatic btn_case(input string nm, input logic [31:0] ctl, input pbr_pkg::pbr_cond_s cc, input int n,
		input int falls, input logic [2:0] mode, input logic [2:0] flags);
		int f0;
		f0 = n_falls;
		cond <= cc;
		wr(pbr_pkg::REG_CTRL, ctl);
		push(n);
		check("reset count", n_falls - f0, falls);
		if (falls > 0)
		begin
			check("reset width", last_low, RP);
			check("mode", op_mode, mode);
		end
		rd(pbr_pkg::REG_BUTTON);
		check("flags", d, flags);
		rd(pbr_pkg::REG_BUTTON);
		check("flags cleared", d, 32'h0);
		$display("test %s done", nm);
	endtask : btn_case
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : conclude
	initial
	begin
		cyc(90000);
		n_errors++;
		conclude();
	end
	initial
	begin
		base = '0;
		base.battery_present = 1'b1;
		base.input_valid = 1'b1;
		base.input_stable = 1'b1;
		base.input_in_window = 1'b1;
		battery_supply = '0;
		battery_supply.battery_present = 1'b1;
		nowin = base;
		nowin.input_in_window = 1'b0;
		input_supply = base;
		input_supply.battery_present = 1'b0;
		cond = base;
		cyc(2);
		aresetn <= 1'b1;
		cyc(1);
		check("notify idle", host_notify, 1'b0);
		check("reset idle", reset_out_n, 1'b1);
		rd(pbr_pkg::REG_CTRL);
		check("ctrl reset", d, 32'h0000_0060);
		rd(8'h0C);
		check("unmapped rresp", r, pbr_pkg::RESP_SLVERR);
		wr(pbr_pkg::REG_STATUS, 32'h0000_00FF);
		check("read-only bresp", r, pbr_pkg::RESP_SLVERR);
		rd(pbr_pkg::REG_STATUS);
		check("status idle", d[9:0], 10'h001);
		$display("test reset done");
		for (int i = 0; i < 10; i++)
		begin
			c = base;
			case (i)
				0: c.input_overvoltage = 1'b1;
				1: c.input_undervoltage = 1'b1;
				2: c.input_current_limit = 1'b1;
				3: c.input_power_mgmt = 1'b1;
				4: c.safety_timer_fault = 1'b1;
				5: c.temp_zone = pbr_pkg::TEMP_COLD;
				6: c.temp_zone = pbr_pkg::TEMP_COOL;
				7: c.temp_zone = pbr_pkg::TEMP_WARM;
				8: c.temp_zone = pbr_pkg::TEMP_HOT;
				default: c.charge_done = 1'b1;
			endcase
			check("notify before", host_notify, 1'b0);
			cond <= c;
			cyc(8);
			check("notify", host_notify, 1'b1);
			rd(pbr_pkg::REG_STATUS);
			check("status", d[9:0], {c.temp_zone, c.safety_timer_fault, c.input_power_mgmt, c.input_current_limit,
				c.input_undervoltage, c.input_overvoltage, exp_st[i]});
			check("charger", charger, exp_chg[i]);
			cond <= base;
			cyc(2620);
		end
		$display("test conditions done");
		btn_case("wake short", 32'h60, battery_supply, 40, 0, pbr_pkg::MODE_READY, 3'h1);
		btn_case("wake long", 32'h61, battery_supply, 60, 0, pbr_pkg::MODE_READY, 3'h2);
		btn_case("reset select", 32'h62, battery_supply, 110, 0, pbr_pkg::MODE_READY, 3'h1);
		btn_case("ship", 32'h60, battery_supply, 300, 1, pbr_pkg::MODE_SHIP, 3'h5);
		btn_case("hiz", 32'h28, battery_supply, 300, 1, pbr_pkg::MODE_HIZ, 3'h5);
		check("output back on", system_output_en, 1'b1);
		btn_case("prior", 32'h160, base, 300, 1, pbr_pkg::MODE_CHARGE, 3'h5);
		btn_case("no window", 32'h70, nowin, 300, 0, pbr_pkg::MODE_READY, 3'h1);
		btn_case("window", 32'h170, base, 300, 1, pbr_pkg::MODE_CHARGE, 3'h5);
		btn_case("no supply", 32'h60, '0, 300, 0, pbr_pkg::MODE_READY, 3'h0);
		btn_case("charge off", 32'h40, input_supply, 300, 0, pbr_pkg::MODE_READY, 3'h0);
		aresetn <= 1'b0;
		cyc(2);
		aresetn <= 1'b1;
		cyc(1);
		check("reset again", reset_out_n, 1'b1);
		rd(pbr_pkg::REG_CTRL);
		check("ctrl reset again", d, 32'h0000_0060);
		$display("test reset again done");
		conclude();
	end
endmodule : pbr_supervisor_tb
`default_nettype wire
